// ===== design/tifc_ctrl.sv
// Trap flags, nesting control, vector select and request flag bank
//
// Notes on behaviour
// - Nesting-off bit 15 set blocks nesting; entry then raises level to seven.
// - Accumulator A/B overflow trap sets flag bit 14 or 13.
// - Catastrophic overflow trap of A/B sets flag bit 12 or 11.
// - Overflow traps of A/B happen only with enable bit 10 or 9.
// - Catastrophic overflow traps happen only with enable bit 8 set.
// - Invalid accumulator shift math trap sets bit 7.
// - Divide by zero math trap sets bit 6.
// - DMA controller error trap sets bit 5.
// - Any math error trap sets bit 4.
// - Address error trap sets bit 3.
// - Stack error trap sets bit 2.
// - Oscillator failure trap sets bit 1.
// - Alternate table select bit 15 picks the alternate vector table.
// - Read-only bit 14 shows an active interrupt hold instruction.
// - Bits 13 to 3 of the vector register read zero.
// - Polarity bits 2..0: one is falling edge, zero rising edge.
// - Flag bits 14..8 set by their own peripheral requests.
// - Flag bits 7..0 set by their requests, bit 0 by external input 0.
// - Request flags set by hardware stay set until software clears.
// - Priority level is read-only while nesting is off.
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module tifc_ctrl (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // Trap causes from the core, one-cycle pulses
  input wire logic accAOvf,
  input wire logic accBOvf,
  input wire logic accACat,
  input wire logic accBCat,
  input wire logic badShift,
  input wire logic divZero,
  input wire logic dmaFault,
  input wire logic addrFault,
  input wire logic stackFault,
  input wire logic oscFault,
  // Core status and entry
  input wire logic irqHold,
  input wire logic irqEntry,
  input wire logic [2:0] irqEntryLevel,
  // Request sources
  input wire logic [2:0] extIn,
  input wire logic [14:1] periphReq,
  // Results to the core
  output logic trapReq,
  output logic mathTrap,
  output logic nestingOff,
  output logic altTableSelect,
  output logic [2:0] extEdge,
  output logic [15:0] requestFlags,
  output logic [2:0] cpuLevel
);

  logic [15:0] trap_reg;
  logic [15:0] trap_next;
  logic [15:0] vec_reg;
  logic [15:0] vec_next;
  logic [15:0] flag_reg;
  logic [15:0] flag_next;
  logic [2:0] level_reg;
  logic [2:0] level_next;
  logic [2:0] extPrev_reg;
  wire [2:0] edgeNow;
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic addrPhase;
  logic rdReq;
  logic wTrap;
  logic wVec;
  logic wFlag;
  logic wLevel;
  logic setOvA;
  logic setOvB;
  logic setCatA;
  logic setCatB;
  logic mathEv;
  logic anyTrap;
  logic [15:0] trapSet;
  logic [15:0] flagSet;
  logic [31:0] rdData;

  // Bus decode; a read right behind a write waits one cycle so it
  // sees the freshly written value
  assign addrPhase = hsel & hready & htrans[1];
  assign rdReq = hsel & htrans[1] & ~hwrite;
  // Held low while frozen so no transfer completes untaken
  assign hreadyout = clkEn & ~(wrPend_reg & rdReq);
  assign hresp = tifc_pkg::HRESP_OKAY;

  // Write strobes fall in the data phase, when hwdata is valid
  assign wTrap = clkEn & wrPend_reg & (wrAddr_reg == tifc_pkg::OFS_TRAP);
  assign wVec = clkEn & wrPend_reg & (wrAddr_reg == tifc_pkg::OFS_VEC);
  assign wFlag = clkEn & wrPend_reg & (wrAddr_reg == tifc_pkg::OFS_FLAG);
  assign wLevel = clkEn & wrPend_reg
                  & (wrAddr_reg == tifc_pkg::OFS_LEVEL);

  // Address phase capture for writes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= tifc_pkg::OFS_TRAP;
    end else if (clkEn) begin
      wrPend_reg <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_reg <= haddr[tifc_pkg::DEC_W-1:0];
      end
    end
  end

  // Read mux; unmapped offsets read zero and writes there are dropped
  always_comb begin
    rdData = tifc_pkg::RD_ZERO;
    unique case (haddr[tifc_pkg::DEC_W-1:0])
      tifc_pkg::OFS_TRAP: rdData[15:0] = trap_reg;
      tifc_pkg::OFS_VEC: begin
        rdData[15:0] = vec_reg & tifc_pkg::VEC_WMASK;
        rdData[tifc_pkg::HOLD_BIT] = irqHold;
      end
      tifc_pkg::OFS_FLAG: rdData[15:0] = flag_reg;
      tifc_pkg::OFS_LEVEL: rdData[2:0] = level_reg;
      default: rdData = tifc_pkg::RD_ZERO;
    endcase
  end

  // Read data register, loaded at the accepted address phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hrdata <= tifc_pkg::RD_ZERO;
    end else if (clkEn && addrPhase && !hwrite) begin
      hrdata <= rdData;
    end
  end

  // Trap causes, each gated by its enable where one exists
  assign setOvA = accAOvf & trap_reg[tifc_pkg::OVA_TE];
  assign setOvB = accBOvf & trap_reg[tifc_pkg::OVB_TE];
  assign setCatA = accACat & trap_reg[tifc_pkg::CAT_TE];
  assign setCatB = accBCat & trap_reg[tifc_pkg::CAT_TE];
  assign mathEv = setOvA | setOvB | setCatA | setCatB
                  | badShift | divZero;
  assign anyTrap = mathEv | dmaFault | addrFault | stackFault | oscFault;

  // Set vector for the trap register
  always_comb begin
    trapSet = tifc_pkg::TRAP_RST;
    trapSet[tifc_pkg::OVA_FLAG] = setOvA;
    trapSet[tifc_pkg::OVB_FLAG] = setOvB;
    trapSet[tifc_pkg::CATA_FLAG] = setCatA;
    trapSet[tifc_pkg::CATB_FLAG] = setCatB;
    trapSet[tifc_pkg::SHIFT_FLAG] = badShift;
    trapSet[tifc_pkg::DIV_FLAG] = divZero;
    trapSet[tifc_pkg::DMA_FLAG] = dmaFault;
    trapSet[tifc_pkg::MATH_FLAG] = mathEv;
    trapSet[tifc_pkg::ADDR_FLAG] = addrFault;
    trapSet[tifc_pkg::STACK_FLAG] = stackFault;
    trapSet[tifc_pkg::OSC_FLAG] = oscFault;
  end

  // Set beats a same-cycle software clear, so no trap is lost
  assign trap_next = (wTrap ? (hwdata[15:0] & tifc_pkg::TRAP_WMASK)
                     : trap_reg) | trapSet;

  // Trap register and trap pulses to the core
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trap_reg <= tifc_pkg::TRAP_RST;
      trapReq <= 1'b0;
      mathTrap <= 1'b0;
    end else if (clkEn) begin
      trap_reg <= trap_next;
      trapReq <= anyTrap;
      mathTrap <= mathEv;
    end
  end

  assign nestingOff = trap_reg[tifc_pkg::NEST_BIT];

  // Vector select and polarity; the hold bit is never stored
  assign vec_next = wVec ? (hwdata[15:0] & tifc_pkg::VEC_WMASK) : vec_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vec_reg <= tifc_pkg::VEC_RST;
    end else if (clkEn) begin
      vec_reg <= vec_next;
    end
  end

  assign altTableSelect = vec_reg[tifc_pkg::ALT_BIT];

  // Edge detect per external input, polarity chosen per input
  genvar gi;
  generate
    for (gi = 0; gi < tifc_pkg::EXT_N; gi++) begin : g_ext
      assign edgeNow[gi] = vec_reg[gi]
                           ? (extPrev_reg[gi] & ~extIn[gi])
                           : (~extPrev_reg[gi] & extIn[gi]);
    end
  endgenerate

  // Previous input sample and registered edge pulses
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      extPrev_reg <= tifc_pkg::EXT_RST;
      extEdge <= tifc_pkg::EXT_RST;
    end else if (clkEn) begin
      extPrev_reg <= extIn;
      extEdge <= edgeNow;
    end
  end

  // Request flag set vector; bit 15 is not implemented
  always_comb begin
    flagSet = tifc_pkg::FLAG_RST;
    flagSet[tifc_pkg::PER_HI:tifc_pkg::PER_LO] = periphReq;
    flagSet[tifc_pkg::EXT0_FLAG] = edgeNow[0];
  end

  // Flags hold until software writes zero; a new request wins
  assign flag_next = (wFlag ? (hwdata[15:0] & tifc_pkg::FLAG_WMASK)
                     : flag_reg) | flagSet;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flag_reg <= tifc_pkg::FLAG_RST;
    end else if (clkEn) begin
      flag_reg <= flag_next;
    end
  end

  assign requestFlags = flag_reg;

  // Priority level: entry from the core wins over a software write
  always_comb begin
    level_next = level_reg;
    if (wLevel && !nestingOff) begin
      level_next = hwdata[2:0];
    end
    if (irqEntry) begin
      level_next = nestingOff ? tifc_pkg::LVL_MASKED : irqEntryLevel;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      level_reg <= tifc_pkg::LVL_RST;
    end else if (clkEn) begin
      level_reg <= level_next;
    end
  end

  assign cpuLevel = level_reg;

  // Checks
  AST_NEST_MASK: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && irqEntry && nestingOff |=> cpuLevel == 3'h7)
    else $error("entry with nesting off did not mask");

  AST_OVA_FLAG: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && accAOvf && trap_reg[10] |=> trap_reg[14] && trap_reg[4])
    else $error("overflow A flag not set");

  AST_CATB_FLAG: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && accBCat && trap_reg[8] |=> trap_reg[11] && trapReq)
    else $error("catastrophic B flag not set");

  AST_OVB_GATED: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && accBOvf && !trap_reg[9] && !trap_reg[13] && !wTrap
    |=> !trap_reg[13])
    else $error("overflow B trapped while disabled");

  AST_CAT_GATED: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && accACat && !trap_reg[8] && !trap_reg[12] && !wTrap
    |=> !trap_reg[12])
    else $error("catastrophic trap while disabled");

  AST_SHIFT: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && badShift |=> trap_reg[7] && trap_reg[4] && mathTrap)
    else $error("shift error not flagged");

  AST_DIV: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && divZero |=> trap_reg[6] && trap_reg[4])
    else $error("divide error not flagged");

  AST_DMA: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && dmaFault |=> trap_reg[5] && trapReq)
    else $error("dma error not flagged");

  AST_MATH_ONLY: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && !trap_reg[4] && !mathEv && !wTrap |=> !trap_reg[4])
    else $error("math flag set without cause");

  AST_ADDR: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && addrFault |=> trap_reg[3] && trapReq)
    else $error("address error not flagged");

  AST_STACK: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && stackFault |=> trap_reg[2] && trapReq)
    else $error("stack error not flagged");

  AST_OSC: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && oscFault |=> trap_reg[1] && trapReq)
    else $error("oscillator error not flagged");

  AST_ALT: assert property (@(posedge clock) disable iff (sys_rst)
    wVec |=> altTableSelect == $past(hwdata[15]))
    else $error("alternate table select not written");

  AST_HOLD_RD: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && addrPhase && !hwrite && haddr[7:0] == 8'h04
    |=> hrdata[14] == $past(irqHold) && hrdata[13:3] == 11'h000)
    else $error("vector register readback wrong");

  AST_EDGE: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && vec_reg[0] && extPrev_reg[0] && !extIn[0]
    |=> extEdge[0] && requestFlags[0])
    else $error("falling edge on input 0 missed");

  AST_PERIPH: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && periphReq[8] |=> requestFlags[8])
    else $error("peripheral request not flagged");

  AST_FLAG_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && flag_reg[14] && !wFlag |=> flag_reg[14])
    else $error("request flag dropped without a write");

  AST_LEVEL_LOCK: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && nestingOff && !irqEntry |=> cpuLevel == $past(cpuLevel))
    else $error("level changed while nesting off");

  AST_TRAP_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && trap_reg[3] && !wTrap |=> trap_reg[3])
    else $error("trap flag dropped without a write");

endmodule

// ===== pkg/tifc_pkg.sv
// Constants shared by the trap and request flag controller
package tifc_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_TRAP = 8'h00;
  localparam logic [7:0] OFS_VEC = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h08;
  localparam logic [7:0] OFS_LEVEL = 8'h0C;
  localparam int DEC_W = 8;
  localparam int REG_W = 16;
  localparam int LVL_W = 3;
  localparam int EXT_N = 3;
  // Trap and nesting control fields
  localparam int NEST_BIT = 15;
  localparam int OVA_FLAG = 14;
  localparam int OVB_FLAG = 13;
  localparam int CATA_FLAG = 12;
  localparam int CATB_FLAG = 11;
  localparam int OVA_TE = 10;
  localparam int OVB_TE = 9;
  localparam int CAT_TE = 8;
  localparam int SHIFT_FLAG = 7;
  localparam int DIV_FLAG = 6;
  localparam int DMA_FLAG = 5;
  localparam int MATH_FLAG = 4;
  localparam int ADDR_FLAG = 3;
  localparam int STACK_FLAG = 2;
  localparam int OSC_FLAG = 1;
  // Vector select and edge polarity fields
  localparam int ALT_BIT = 15;
  localparam int HOLD_BIT = 14;
  localparam int RSVD_HI = 13;
  localparam int RSVD_LO = 3;
  // Request flag fields
  localparam int EXT0_FLAG = 0;
  localparam int PER_LO = 1;
  localparam int PER_HI = 14;
  // Writable masks and reset values
  localparam logic [15:0] TRAP_WMASK = 16'hFFFE;
  localparam logic [15:0] VEC_WMASK = 16'h8007;
  localparam logic [15:0] FLAG_WMASK = 16'h7FFF;
  localparam logic [15:0] TRAP_RST = 16'h0000;
  localparam logic [15:0] VEC_RST = 16'h0000;
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [2:0] LVL_RST = 3'h0;
  localparam logic [2:0] LVL_MASKED = 3'h7;
  localparam logic [2:0] EXT_RST = 3'h0;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
endpackage

// ===== bench/tifc_src.sv
// Far-side model: trap causes and peripheral requests as pulses
`timescale 1ns/1ps
module tifc_src (
  // Clock and command
  input wire logic clock,
  input wire logic go,
  input wire logic [4:0] sel,
  // Pulses: 0..9 trap causes, 10..23 peripheral requests
  output logic [23:0] pul = 24'h000000
);
  // One line per command, dropped after a cycle, so the flag must
  // hold by itself until software clears it
  always @(posedge clock) begin
    pul <= go ? (24'h000001 << sel) : 24'h000000;
  end
endmodule

// ===== bench/trap_and_irq_flag_control_tb.sv
// Self-checking bench for the trap and request flag controller
`timescale 1ns/1ps
module trap_and_irq_flag_control_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic [1:0] pulse = 2'h0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout;
  logic [1:0] hresp;
  logic [31:0] hrdata, q;
  logic irqHold = 1'b0;
  logic irqEntry = 1'b0;
  logic [2:0] irqEntryLevel = 3'h0;
  logic [2:0] extIn = 3'h0;
  logic go = 1'b0;
  logic [4:0] sel = 5'h00;
  logic [23:0] pul;
  logic trapReq, mathTrap, nestingOff, altTableSelect;
  logic [2:0] extEdge, cpuLevel;
  logic [15:0] requestFlags;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Flags expected per cause; overflow, shift and divide causes also mark math error
  localparam logic [15:0] TEXP [10] = '{16'h4010, 16'h2010, 16'h1010,
    16'h0810, 16'h0090, 16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002};

  always #10 clock = ~clock;

  tifc_src src (.clock(clock), .go(go), .sel(sel), .pul(pul));

  tifc_ctrl uut (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .accAOvf(pul[0]), .accBOvf(pul[1]), .accACat(pul[2]),
    .accBCat(pul[3]), .badShift(pul[4]), .divZero(pul[5]),
    .dmaFault(pul[6]), .addrFault(pul[7]), .stackFault(pul[8]),
    .oscFault(pul[9]), .irqHold(irqHold), .irqEntry(irqEntry),
    .irqEntryLevel(irqEntryLevel), .extIn(extIn),
    .periphReq(pul[23:10]), .trapReq(trapReq), .mathTrap(mathTrap),
    .nestingOff(nestingOff), .altTableSelect(altTableSelect),
    .extEdge(extEdge), .requestFlags(requestFlags), .cpuLevel(cpuLevel));

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Judge ready between edges, where it is settled
  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge clock);
    while (hreadyout !== 1'b1 && n < 16) begin
      n++;
      @(negedge clock);
    end
    if (n == 16) begin
      n_mismatch++;
      $display("mismatch at %0t: bus never ready", $time);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (wr) hwdata <= d;
    wait_rdy();
    @(posedge clock);
    q = hrdata;
  endtask

  // Write, then a read in its data phase: one wait state is due
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
    input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_rdy();
    @(posedge clock);
    hwrite <= 1'b0;
    hwdata <= d;
    @(negedge clock);
    while (hreadyout !== 1'b1 && n < 16) begin
      n++;
      @(negedge clock);
    end
    @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_rdy();
    @(posedge clock);
    cmp(hrdata, {16'h0000, exp});
    cmp(n, 1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 32'h00000000);
    cmp(q, {16'h0000, exp});
  endtask

  task automatic fire(input int idx);
    @(posedge clock);
    go <= 1'b1;
    sel <= idx[4:0];
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    pulse = {trapReq, mathTrap};
    @(posedge clock);
  endtask

  task automatic enter(input logic [2:0] lvl);
    @(posedge clock);
    irqEntry <= 1'b1;
    irqEntryLevel <= lvl;
    @(posedge clock);
    irqEntry <= 1'b0;
    @(posedge clock);
  endtask

  // Count edge pulses after moving one external input
  task automatic edge_try(input int i, input logic lvl, input int exp);
    int seen;
    seen = 0;
    @(posedge clock);
    extIn[i] <= lvl;
    repeat (5) begin
      @(negedge clock);
      if (extEdge[i] === 1'b1) seen++;
    end
    cmp(seen, exp);
  endtask

  task automatic t_reset();
    rd(8'h00, 16'h0000);
    rd(8'h04, 16'h0000);
    rd(8'h08, 16'h0000);
    rd(8'h0C, 16'h0000);
    rd(8'h10, 16'h0000);
    cmp({30'h0, hresp}, 32'h0);
  endtask

  task automatic t_traps();
    bus(1'b1, 8'h00, 32'h00000700);
    for (int i = 0; i < 10; i++) begin
      fire(i);
      cmp({30'h0, pulse}, (i < 6) ? 32'h3 : 32'h2);
      rd(8'h00, TEXP[i] | 16'h0700);
      bus(1'b1, 8'h00, 32'h00000700);
    end
    bus(1'b1, 8'h00, 32'h00000000);
    for (int i = 0; i < 4; i++) fire(i);
    cmp({30'h0, pulse}, 32'h0);
    rd(8'h00, 16'h0000);
    bus(1'b1, 8'h00, 32'h00000400);
    fire(1);
    rd(8'h00, 16'h0400);
    fire(0);
    rd(8'h00, 16'h4410);
    bus(1'b1, 8'h00, 32'h00000100);
    fire(3);
    rd(8'h00, 16'h0910);
    bus(1'b1, 8'h00, 32'h00000000);
  endtask

  task automatic t_nest();
    bus(1'b1, 8'h00, 32'h00008000);
    @(negedge clock);
    cmp(nestingOff, 1'b1);
    bus(1'b1, 8'h0C, 32'h00000005);
    rd(8'h0C, 16'h0000);
    enter(3'h2);
    cmp(cpuLevel, 3'h7);
    bus(1'b1, 8'h00, 32'h00000000);
    @(negedge clock);
    cmp(nestingOff, 1'b0);
    bus(1'b1, 8'h0C, 32'h00000003);
    rd(8'h0C, 16'h0003);
    enter(3'h2);
    cmp(cpuLevel, 3'h2);
  endtask

  task automatic t_vec();
    @(posedge clock);
    irqHold <= 1'b1;
    bus(1'b1, 8'h04, 32'h0000FFFF);
    rd(8'h04, 16'hC007);
    cmp(altTableSelect, 1'b1);
    irqHold <= 1'b0;
    rd(8'h04, 16'h8007);
    wr_rd(8'h04, 32'h00000002, 16'h0002);
    bus(1'b1, 8'h04, 32'h00000000);
    @(negedge clock);
    cmp(altTableSelect, 1'b0);
  endtask

  // Causes and requests seen with the enable low leave no trace
  task automatic t_freeze();
    @(posedge clock);
    clkEn <= 1'b0;
    fire(6);
    fire(10);
    @(posedge clock);
    clkEn <= 1'b1;
    rd(8'h00, 16'h0000);
    cmp({30'h0, pulse}, 32'h0);
    rd(8'h08, 16'h0000);
  endtask

  task automatic t_ext();
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, 8'h04, (p == 1) ? 32'h00000007 : 32'h00000000);
      for (int i = 0; i < 3; i++) begin
        edge_try(i, 1'b1, 1 - p);
        edge_try(i, 1'b0, p);
      end
    end
    rd(8'h08, 16'h0001);
    bus(1'b1, 8'h08, 32'h00000000);
  endtask

  task automatic t_flags();
    for (int i = 1; i < 15; i++) begin
      fire(9 + i);
      rd(8'h08, 16'h0001 << i);
      cmp(requestFlags, 16'h0001 << i);
      bus(1'b1, 8'h08, 32'h00000000);
    end
    rd(8'h08, 16'h0000);
    bus(1'b1, 8'h08, 32'h0000FFFF);
    rd(8'h08, 16'h7FFF);
    bus(1'b1, 8'h08, 32'h00000000);
  endtask

  // Reset for six cycles, then each scenario in turn
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_traps();
    t_nest();
    t_vec();
    t_ext();
    t_flags();
    t_freeze();
    end_of_test();
  end
endmodule
